// [pkg/hrf_pkg.sv]
// Purpose: Shared constants and types of the host reply formatter.
// Assumes: One 200 MHz clock (pclk); register access over APB with 32-bit data.
// Notes: Reply words are bytes; a time value is four bytes, high byte first.

package hrf_pkg;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] HRF_CTRL_OFF = 12'h000;
  localparam logic [11:0] HRF_PIN_DATA_OFF = 12'h004;
  localparam logic [11:0] HRF_PIN_CTRL_OFF = 12'h008;
  localparam logic [11:0] HRF_EXEC_VER_OFF = 12'h00C;
  localparam logic [11:0] HRF_FUNC_VER_OFF = 12'h010;
  localparam logic [11:0] HRF_STATUS_OFF = 12'h014;
  localparam logic [1:0] HRF_CTRL_RST = 2'h0;
  localparam logic [3:0] HRF_PIN_RST = 4'h0;
  localparam logic [31:0] HRF_EXEC_VER_RST = 32'h00000000;
  localparam logic [15:0] HRF_FUNC_VER_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Reply lengths and result codes
  // ----------------------------------------------------------------
  localparam logic [7:0] HRF_LEN_PCM = 8'h08;
  localparam logic [7:0] HRF_LEN_MPEG = 8'h0C;
  localparam logic [7:0] HRF_LEN_NOISE = 8'h08;
  localparam logic [7:0] HRF_LEN_VER = 8'h04;
  localparam logic [7:0] HRF_LEN_PIN = 8'h02;
  localparam logic [7:0] HRF_LEN_LOCK = 8'h01;
  localparam logic [7:0] HRF_LEN_DIGIN = 8'h04;
  localparam logic [7:0] HRF_LEN_TIME = 8'h08;
  localparam logic [7:0] HRF_RES_OK = 8'h80;
  localparam logic [7:0] HRF_RES_BAD_OP = 8'h81;
  localparam logic [7:0] HRF_RES_BAD_PARAM = 8'h82;
  localparam logic [7:0] HRF_RES_NOT_READY = 8'h83;
  localparam logic [7:0] HRF_RES_OVERFLOW = 8'h84;
  localparam logic [7:0] HRF_RES_READY = 8'h85;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HRF_FUNC_NONE = 2'h0;
  localparam logic [1:0] HRF_FUNC_PCM = 2'h1;
  localparam logic [1:0] HRF_FUNC_MPEG = 2'h2;
  localparam logic [1:0] HRF_FUNC_NOISE = 2'h3;
  localparam logic [1:0] HRF_ALG_MPEG = 2'h1;
  localparam logic [2:0] HRF_ERR_NONE = 3'h0;
  localparam logic [2:0] HRF_ERR_SYNC = 3'h1;
  localparam logic [2:0] HRF_ERR_CRC = 3'h2;
  localparam logic [2:0] HRF_ERR_RATE = 3'h3;
  localparam logic [2:0] HRF_ERR_DRATE = 3'h4;
  localparam logic [2:0] HRF_ERR_UNDER = 3'h5;

  typedef enum logic [3:0] {
    HRF_OP_NOP, HRF_OP_STAT, HRF_OP_PIN_IO, HRF_OP_SYNTH_CFG, HRF_OP_VERSION,
    HRF_OP_MEM_READ, HRF_OP_DIGIN_STAT, HRF_OP_TIME_STAMP, HRF_OP_SETUP, HRF_OP_BAD
  } hrf_op_t;

  // A command as handed over by the parser: opcode, parameter or word count, address.
  typedef struct packed {
    hrf_op_t op;
    logic [5:0] count;
    logic [15:0] addr;
  } hrf_cmd_t;

  // Live decoder state supplied by the firmware.
  typedef struct packed {
    logic [7:0] func_status;
    logic [1:0] run_state;
    logic [2:0] frame_decode_error_code;
    logic [15:0] time_difference;
    logic [1:0] coding_tier;
    logic crc_absent_flag;
    logic [3:0] bit_rate;
    logic [1:0] sampling_freq_code;
    logic pad;
    logic priv;
    logic [1:0] enc_mode;
    logic [1:0] mode_ext;
    logic copyright;
    logic original;
    logic [1:0] emphasis;
  } hrf_dec_stat_t;

  // Digital input receiver state; category_code arrives in channel-status order.
  typedef struct packed {
    logic [1:0] rate_code;
    logic [7:0] category_code;
    logic preemphasis_flag;
    logic copyright;
    logic non_pcm;
    logic [6:0] receiver_status_bits;
  } hrf_digin_t;

  // Lock flags and the two time counts (90 kHz ticks, low 32 bits).
  typedef struct packed {
    logic audio_synth_locked;
    logic core_synth_locked;
    logic [31:0] presentation_time;
    logic [31:0] system_time_count;
  } hrf_clk_stat_t;

endpackage

// [rtl/hrf_formatter.sv]
// Purpose: Builds the byte-wide reply stream returned to the host, one word per READ.
// Assumes: Parser, firmware and memory run on pclk; memory data follows its address same cycle.
// Notes: The physical host port and command decoding live elsewhere.
//
// Local design decisions: the register offsets and the APB slave port.

`timescale 1ns/1ps
`default_nettype none

// Contract
// - PCM/matrix status reply is eight words; words 3-6 and 8 zero, word 7 version.
// - MPEG reply: error code word 2, time difference words 5-6 high first, header fields words 7-9, zeros in words 3-4 and 10-12.
// - Decode error codes 0 none, 1 sync, 2 CRC, 3 rate, 4 data rate, 5 underflow.
// - Algorithm tag reads 1 for MPEG.
// - Coding tier reads 1 layer three, 2 layer two, 3 layer one.
// - CRC-absent flag is 0 with CRC word, 1 without.
// - Sampling code 0 is 44.1 kHz, 1 is 48 kHz, 2 is 32 kHz.
// - Encoding mode 0 stereo, 1 joint, 2 dual, 3 single channel.
// - ROM revision reply returns four executive version bytes, one per READ.
// - Pin I/O reply returns latest pin data and pin control contents.
// - Lock state reply is one byte with audio and core lock flags.
// - Memory read of N locations returns N words over 4N READs.
// - Input rate reported 0 for 44.1, 2 for 48/96, 3 for 32 kHz.
// - Category code is sent bit-reversed, bit 0 rightmost.
// - Pre-emphasis is meaningful only when PCM flag is 0.
// - PCM flag is 0 for PCM audio, 1 for encoded data.
// - Receiver status byte holds seven receiver condition bits.
// - Time stamp reply: presentation time four bytes, then system time four bytes.
// - Each time value is low 32 bits of 90 kHz count, high byte first.
// - Progress word gives remaining parameter words or remaining reply words.
// - Progress word is omitted when the count is zero.
// - Every exchange ends with an interpretation result code, 80 to 85 hex.
// - A command arriving while busy is discarded and answered not-ready.
module hrf_formatter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_valid,
  input wire hrf_pkg::hrf_cmd_t cmd,
  input wire logic param_valid,
  input wire logic host_read,
  output logic reply_valid,
  output logic [7:0] reply_byte,
  input wire hrf_pkg::hrf_dec_stat_t dec_stat,
  input wire hrf_pkg::hrf_digin_t digin,
  input wire hrf_pkg::hrf_clk_stat_t clk_stat,
  output logic [15:0] mem_addr,
  input wire logic [31:0] mem_data,
  output logic [1:0] active_func,
  output logic [3:0] pin_data,
  output logic [3:0] pin_ctrl
);
  import hrf_pkg::*;

  typedef enum logic [1:0] {HRF_IDLE, HRF_PARAM, HRF_REMAINING_WORD_COUNT, HRF_REPLY} hrf_state_t;

  hrf_state_t state_reg;
  hrf_op_t op_reg;
  logic [1:0] ctrl_reg;
  logic [3:0] pin_data_reg;
  logic [3:0] pin_ctrl_reg;
  logic [31:0] exec_ver_reg;
  logic [15:0] func_ver_reg;
  logic [5:0] param_left_reg;
  logic [5:0] words_reg;
  logic [15:0] base_reg;
  logic [7:0] len_reg;
  logic [7:0] pos_reg;
  logic [7:0] result_reg;
  logic [1:0] func_reg;
  logic reject_reg;
  logic [7:0] reject_cnt_reg;
  logic [7:0] byte_next;
  logic [7:0] reply_byte_reg;
  logic reply_valid_reg;
  logic [7:0] cmd_len;
  logic cmd_take;
  logic cmd_drop;
  logic apb_wr;
  logic apb_hit;
  logic [7:0] status_word [0:11];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Byte b (0 = most significant) of a 32-bit value.
  function automatic logic [7:0] pick_byte(input logic [31:0] val, input logic [1:0] b);
    logic [7:0] res;
    res = 8'h00;
    case (b)
      2'h0: res = val[31:24];
      2'h1: res = val[23:16];
      2'h2: res = val[15:8];
      default: res = val[7:0];
    endcase
    return res;
  endfunction

  // Number of reply words a command produces, before the progress word.
  function automatic logic [7:0] reply_len(input hrf_op_t op, input logic [1:0] fn,
                                           input logic [5:0] cnt);
    logic [7:0] res;
    res = 8'h00;
    case (op)
      HRF_OP_STAT: begin
        case (fn)
          HRF_FUNC_PCM: res = HRF_LEN_PCM;
          HRF_FUNC_MPEG: res = HRF_LEN_MPEG;
          HRF_FUNC_NOISE: res = HRF_LEN_NOISE;
          default: res = 8'h00;
        endcase
      end
      HRF_OP_PIN_IO: res = HRF_LEN_PIN;
      HRF_OP_SYNTH_CFG: res = HRF_LEN_LOCK;
      HRF_OP_VERSION: res = HRF_LEN_VER;
      HRF_OP_MEM_READ: res = {cnt, 2'b00}; // Four bytes per memory word.
      HRF_OP_DIGIN_STAT: res = HRF_LEN_DIGIN;
      HRF_OP_TIME_STAMP: res = HRF_LEN_TIME;
      default: res = 8'h00;
    endcase
    return res;
  endfunction

  // Number of parameter words a command takes from the host.
  function automatic logic [5:0] param_len(input hrf_op_t op, input logic [5:0] cnt);
    logic [5:0] res;
    res = 6'h00;
    case (op)
      HRF_OP_SYNTH_CFG: res = 6'h01;
      HRF_OP_PIN_IO: res = 6'h02;
      HRF_OP_SETUP: res = cnt;
      default: res = 6'h00;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------

  // Zero wait states keep the host port free of bus stalls.
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_hit = (paddr == HRF_CTRL_OFF) || (paddr == HRF_PIN_DATA_OFF) ||
                   (paddr == HRF_PIN_CTRL_OFF) || (paddr == HRF_EXEC_VER_OFF) ||
                   (paddr == HRF_FUNC_VER_OFF) || (paddr == HRF_STATUS_OFF);
  assign pslverr = psel && penable && !apb_hit;

  // Register writes; the status word is read-only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= HRF_CTRL_RST;
      pin_data_reg <= HRF_PIN_RST;
      pin_ctrl_reg <= HRF_PIN_RST;
      exec_ver_reg <= HRF_EXEC_VER_RST;
      func_ver_reg <= HRF_FUNC_VER_RST;
    end else if (apb_wr) begin
      case (paddr)
        HRF_CTRL_OFF: ctrl_reg <= pwdata[1:0];
        HRF_PIN_DATA_OFF: pin_data_reg <= pwdata[3:0];
        HRF_PIN_CTRL_OFF: pin_ctrl_reg <= pwdata[3:0];
        HRF_EXEC_VER_OFF: exec_ver_reg <= pwdata;
        HRF_FUNC_VER_OFF: func_ver_reg <= pwdata[15:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Read mux; unmapped addresses return zero with pslverr.
  always_comb begin
    prdata = 32'h00000000;
    case (paddr)
      HRF_CTRL_OFF: prdata = {30'h00000000, ctrl_reg};
      HRF_PIN_DATA_OFF: prdata = {28'h0000000, pin_data_reg};
      HRF_PIN_CTRL_OFF: prdata = {28'h0000000, pin_ctrl_reg};
      HRF_EXEC_VER_OFF: prdata = exec_ver_reg;
      HRF_FUNC_VER_OFF: prdata = {16'h0000, func_ver_reg};
      HRF_STATUS_OFF: prdata = {reject_cnt_reg, result_reg, pos_reg, 5'h00, reject_reg,
                                state_reg};
      default: prdata = 32'h00000000;
    endcase
  end

  assign active_func = ctrl_reg;
  assign pin_data = pin_data_reg;
  assign pin_ctrl = pin_ctrl_reg;

  // ----------------------------------------------------------------
  // Command acceptance and sequencing
  // ----------------------------------------------------------------

  assign cmd_take = cmd_valid && (state_reg == HRF_IDLE) && !reject_reg;
  assign cmd_drop = cmd_valid && !cmd_take;
  assign cmd_len = reply_len(cmd.op, ctrl_reg, cmd.count);

  // Exchange state: parameters first, then progress word, replies and result code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= HRF_IDLE;
      op_reg <= HRF_OP_NOP;
      param_left_reg <= 6'h00;
      words_reg <= 6'h00;
      base_reg <= 16'h0000;
      len_reg <= 8'h00;
      pos_reg <= 8'h00;
      result_reg <= HRF_RES_READY;
      func_reg <= HRF_FUNC_NONE;
    end else begin
      case (state_reg)
        HRF_IDLE: begin
          if (cmd_take) begin
            op_reg <= cmd.op;
            words_reg <= cmd.count;
            base_reg <= cmd.addr;
            func_reg <= ctrl_reg;
            len_reg <= cmd_len;
            pos_reg <= 8'h00;
            param_left_reg <= param_len(cmd.op, cmd.count);
            result_reg <= (cmd.op == HRF_OP_BAD) ? HRF_RES_BAD_OP : HRF_RES_OK;
            if (param_len(cmd.op, cmd.count) != 6'h00) begin
              state_reg <= HRF_PARAM;
            end else if (cmd_len != 8'h00) begin
              state_reg <= HRF_REMAINING_WORD_COUNT;
            end else begin
              state_reg <= HRF_REPLY; // No progress word when nothing remains.
            end
          end
        end
        HRF_PARAM: begin
          // Extra READs here only see the remaining count; a parameter counts it down.
          if (param_valid) begin
            param_left_reg <= param_left_reg - 6'h01;
            if (param_left_reg == 6'h01) begin
              state_reg <= (len_reg != 8'h00) ? HRF_REMAINING_WORD_COUNT : HRF_REPLY;
            end
          end
        end
        HRF_REMAINING_WORD_COUNT: begin
          if (host_read && reply_valid_reg && !reject_reg) begin
            state_reg <= HRF_REPLY;
          end
        end
        HRF_REPLY: begin
          if (host_read && reply_valid_reg && !reject_reg) begin
            if (pos_reg == len_reg) begin
              state_reg <= HRF_IDLE; // Result code was the last word.
            end else begin
              pos_reg <= pos_reg + 8'h01;
            end
          end
        end
        default: state_reg <= HRF_IDLE;
      endcase
    end
  end

  // A command that arrives mid-exchange is dropped and owes one not-ready word.
  // The new arrival wins over the clearing READ so no rejection goes unanswered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reject_reg <= 1'b0;
      reject_cnt_reg <= 8'h00;
    end else begin
      if (cmd_drop) begin
        reject_reg <= 1'b1;
        reject_cnt_reg <= reject_cnt_reg + 8'h01;
      end else if (host_read && reply_valid_reg && reject_reg) begin
        reject_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reply word formatting
  // ----------------------------------------------------------------

  // Memory words are fetched per byte; the address tracks the current word.
  assign mem_addr = base_reg + {8'h00, 2'b00, pos_reg[7:2]};

  // Status words for the three function replies, indexed from word one.
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      status_word[i] = 8'h00; // Unlisted words read zero.
    end
    status_word[0] = dec_stat.func_status;
    case (func_reg)
      HRF_FUNC_MPEG: begin
        status_word[1] = {dec_stat.run_state, 3'b000, dec_stat.frame_decode_error_code};
        status_word[4] = dec_stat.time_difference[15:8];
        status_word[5] = dec_stat.time_difference[7:0];
        status_word[6] = {2'b00, HRF_ALG_MPEG, 1'b0, dec_stat.coding_tier,
                          dec_stat.crc_absent_flag};
        status_word[7] = {dec_stat.bit_rate, dec_stat.sampling_freq_code, dec_stat.pad,
                          dec_stat.priv};
        status_word[8] = {dec_stat.enc_mode, dec_stat.mode_ext, dec_stat.copyright,
                          dec_stat.original, dec_stat.emphasis};
      end
      HRF_FUNC_PCM: begin
        status_word[1] = {dec_stat.run_state, 6'h00};
        status_word[6] = func_ver_reg[7:0];
      end
      default: begin
        status_word[1] = {dec_stat.run_state, 6'h00};
        status_word[6] = func_ver_reg[15:8];
      end
    endcase
  end

  // Selects the byte owed at the current position of the exchange.
  always_comb begin
    byte_next = 8'h00;
    if (reject_reg) begin
      byte_next = HRF_RES_NOT_READY;
    end else begin
      case (state_reg)
        HRF_PARAM: byte_next = {2'b00, param_left_reg};
        HRF_REMAINING_WORD_COUNT: byte_next = len_reg;
        HRF_REPLY: begin
          if (pos_reg == len_reg) begin
            byte_next = result_reg;
          end else begin
            case (op_reg)
              HRF_OP_STAT: byte_next = status_word[pos_reg[3:0]];
              HRF_OP_VERSION: byte_next = pick_byte(exec_ver_reg, pos_reg[1:0]);
              HRF_OP_PIN_IO: byte_next = pos_reg[0] ? {4'h0, pin_ctrl_reg}
                                                    : {4'h0, pin_data_reg};
              HRF_OP_SYNTH_CFG: byte_next = {6'h00, clk_stat.audio_synth_locked,
                                             clk_stat.core_synth_locked};
              HRF_OP_MEM_READ: byte_next = pick_byte(mem_data, pos_reg[1:0]);
              HRF_OP_DIGIN_STAT: begin
                case (pos_reg[1:0])
                  2'h0: byte_next = {digin.rate_code, 6'h00};
                  2'h1: byte_next = {<<{digin.category_code}};
                  2'h2: byte_next = {5'h00, digin.preemphasis_flag & ~digin.non_pcm,
                                     digin.copyright, digin.non_pcm};
                  default: byte_next = {1'b0, digin.receiver_status_bits};
                endcase
              end
              HRF_OP_TIME_STAMP: begin
                // Presentation time first, then system time, each high byte first.
                byte_next = pos_reg[2] ? pick_byte(clk_stat.system_time_count, pos_reg[1:0])
                          : pick_byte(clk_stat.presentation_time, pos_reg[1:0]);
              end
              default: byte_next = 8'h00;
            endcase
          end
        end
        default: byte_next = 8'h00;
      endcase
    end
  end

  // The byte is registered; valid drops for the cycle after each READ while it refreshes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reply_byte_reg <= 8'h00;
      reply_valid_reg <= 1'b0;
    end else begin
      reply_byte_reg <= byte_next;
      reply_valid_reg <= (reject_reg || (state_reg != HRF_IDLE)) && !host_read;
    end
  end

  assign reply_byte = reply_byte_reg;
  assign reply_valid = reply_valid_reg;

endmodule

`default_nettype wire

// [testbench/hrf_monitor.sv]
// Purpose: Port-level timing checks for the host reply formatter.
// Assumes: One pclk domain; presetn is asynchronous and active low.
// Notes: Byte values are judged by the bench; these tie timing to causes.
`timescale 1ns/1ps
`default_nettype none
module hrf_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic cmd_valid,
  input wire hrf_pkg::hrf_cmd_t cmd,
  input wire logic param_valid,
  input wire logic host_read,
  input wire logic reply_valid,
  input wire logic [7:0] reply_byte,
  input wire logic [3:0] pin_data,
  input wire logic [3:0] pin_ctrl
);
  import hrf_pkg::*;
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A register write lands in the access phase of an APB transfer.
  wire logic apb_wr = psel && penable && pwrite;
  wire logic [3:0] wr_low = pwdata[3:0];
  sequence s_read;
    host_read && reply_valid;
  endsequence
  sequence s_new_cmd;
    cmd_valid && !reply_valid;
  endsequence
  property p_read_gap;
    s_read |=> !reply_valid;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("valid held after read");
  property p_hold;
    !cmd_valid && !param_valid ##1 reply_valid && !host_read && !cmd_valid && !param_valid |=>
      reply_valid && $stable(reply_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("reply word moved unread");
  property p_first;
    s_new_cmd ##2 reply_valid |-> reply_byte != 8'h00;
  endproperty
  a_first: assert property (p_first) else $error("zero progress word sent");
  property p_answer;
    cmd_valid && !reply_valid && cmd.op == HRF_OP_VERSION |=> ##1
      reply_valid && reply_byte == HRF_LEN_VER;
  endproperty
  a_answer: assert property (p_answer) else $error("wrong progress word");
  property p_bad;
    cmd_valid && !reply_valid && cmd.op == HRF_OP_BAD |=> ##1
      reply_valid && reply_byte == HRF_RES_BAD_OP;
  endproperty
  a_bad: assert property (p_bad) else $error("bad opcode not flagged");
  property p_not_ready;
    cmd_valid && reply_valid |-> ##[1:3] (reply_valid && reply_byte == HRF_RES_NOT_READY);
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("busy command not refused");
  property p_pin_data;
    apb_wr && paddr == HRF_PIN_DATA_OFF |=> pin_data == $past(wr_low);
  endproperty
  a_pin_data: assert property (p_pin_data) else $error("pin data not updated");
  property p_pin_ctrl;
    apb_wr && paddr == HRF_PIN_CTRL_OFF |=> pin_ctrl == $past(wr_low);
  endproperty
  a_pin_ctrl: assert property (p_pin_ctrl) else $error("pin control not updated");
  property p_unmapped;
    psel && penable && paddr > HRF_STATUS_OFF |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
endmodule
bind hrf_formatter hrf_monitor u_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pslverr, .cmd_valid, .cmd, .param_valid, .host_read, .reply_valid,
  .reply_byte, .pin_data, .pin_ctrl);
`default_nettype wire

// [testbench/hrf_host_model.sv]
// Purpose: Host controller model that collects reply bytes.
// Assumes: A read is a one-cycle pulse taken while reply_valid is high.
// Notes: stall inserts idle cycles between reads to act as a slow host.
`timescale 1ns/1ps
`default_nettype none
module hrf_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [3:0] stall,
  input wire logic reply_valid,
  input wire logic [7:0] reply_byte,
  output logic host_read
);
  logic [7:0] got[$];
  logic [3:0] gap_reg;
  // One read per owed word; the byte is taken at the edge that takes the read.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_read <= 1'h0;
      gap_reg <= 4'h0;
    end else if (host_read) begin
      host_read <= 1'h0;
      gap_reg <= stall;
      got.push_back(reply_byte);
    end else if (enable && reply_valid) begin
      if (gap_reg == 4'h0) begin
        host_read <= 1'h1;
      end else begin
        gap_reg <= gap_reg - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the host reply formatter.
// Assumes: 200 MHz pclk, APB register access, host model on the reply side.
// Notes: Expected bytes carry an ignore mask in their upper byte.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hrf_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cmd_valid = 1'h0;
  hrf_cmd_t cmd = '0;
  logic param_valid = 1'h0;
  logic host_read;
  logic reply_valid;
  logic [7:0] reply_byte;
  hrf_dec_stat_t dec_stat = '0;
  hrf_digin_t digin = '0;
  hrf_clk_stat_t clk_stat = '0;
  logic [15:0] mem_addr;
  logic [31:0] mem_data;
  logic rd_en = 1'h0;
  logic [3:0] stall = 4'h3;
  logic [15:0] exp_q[$];
  logic [31:0] rdat;
  logic rerr;
  logic [2:0] e;
  logic [1:0] t;
  logic [7:0] cc_tab[3] = '{8'h01, 8'h2C, 8'hC0};
  logic [1:0] rate_tab[3] = '{2'h0, 2'h2, 2'h3};
  int failures = 0;
  int total_checks = 0;
  hrf_formatter DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cmd_valid, .cmd, .param_valid, .host_read, .reply_valid,
    .reply_byte, .dec_stat, .digin, .clk_stat, .mem_addr, .mem_data, .active_func(),
    .pin_data(), .pin_ctrl());
  hrf_host_model host (.pclk, .presetn, .enable(rd_en), .stall, .reply_valid, .reply_byte,
    .host_read);
  // Memory answers in the same cycle; the pattern makes each byte traceable.
  assign mem_data = {mem_addr, ~mem_addr};
  // Free-running bus clock.
  always #2.5 pclk = ~pclk;
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev8[k] = v[7 - k];
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic timeout();
    failures++;
    complete_run();
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n == 20) timeout();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // Issues a command, an optional busy command and then its parameters, then reads it all.
  task automatic run(input hrf_op_t op, input logic [5:0] cnt, input int np, input logic drop);
    int n = 0;
    host.got.delete();
    cmd <= '{op, cnt, 16'h0100};
    cmd_valid <= 1'h1;
    @(posedge pclk);
    cmd_valid <= 1'h0;
    if (drop) begin
      @(posedge pclk);
      cmd <= '{HRF_OP_NOP, 6'h0, 16'h0};
      cmd_valid <= 1'h1;
      @(posedge pclk);
      cmd_valid <= 1'h0;
    end
    repeat (np) begin
      @(posedge pclk);
      param_valid <= 1'h1;
      @(posedge pclk);
      param_valid <= 1'h0;
    end
    rd_en <= 1'h1;
    while (host.got.size() < exp_q.size() && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n == 500) timeout();
    repeat (4) @(posedge pclk);
    rd_en <= 1'h0;
    check("reply length", host.got.size(), exp_q.size());
    foreach (exp_q[i])
      if (i < host.got.size())
        check("reply word", {24'h0, host.got[i] & ~exp_q[i][15:8]}, {24'h0, exp_q[i][7:0]});
    check("idle after result", {31'h0, reply_valid}, 32'h0);
    exp_q.delete();
    $display("exchange %s done", op.name());
  endtask
  // Main sequence: registers first, then every kind of exchange except NOP and SETUP.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(HRF_STATUS_OFF, 1'h0, 32'h0);
    check("reset result", {24'h0, rdat[23:16]}, {24'h0, HRF_RES_READY});
    apb(HRF_PIN_DATA_OFF, 1'h1, 32'h0000000A);
    apb(HRF_PIN_CTRL_OFF, 1'h1, 32'h00000005);
    apb(HRF_EXEC_VER_OFF, 1'h1, 32'hA1B2C3D4);
    apb(HRF_FUNC_VER_OFF, 1'h1, 32'h00005A3C);
    apb(12'h018, 1'h1, 32'hFFFFFFFF);
    check("unmapped error", {31'h0, rerr}, 32'h1);
    check("unmapped data", rdat, 32'h0);
    clk_stat <= {2'h2, 32'h12345678, 32'h9ABCDEF0};
    exp_q = '{HRF_LEN_VER, 8'hA1, 8'hB2, 8'hC3, 8'hD4, HRF_RES_OK};
    run(HRF_OP_VERSION, 6'h0, 0, 1'h0);
    stall <= 4'h0;
    exp_q = '{HRF_LEN_PIN, 8'h0A, 8'h05, HRF_RES_OK};
    run(HRF_OP_PIN_IO, 6'h0, 2, 1'h0);
    exp_q = '{HRF_LEN_LOCK, 8'h02, HRF_RES_OK};
    run(HRF_OP_SYNTH_CFG, 6'h0, 1, 1'h0);
    exp_q = '{8'h08, 8'h01, 8'h00, 8'hFE, 8'hFF, 8'h01, 8'h01, 8'hFE, 8'hFE, HRF_RES_OK};
    run(HRF_OP_MEM_READ, 6'h2, 0, 1'h0);
    exp_q = '{HRF_LEN_TIME, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'hDE, 8'hF0, 8'h80};
    run(HRF_OP_TIME_STAMP, 6'h0, 0, 1'h0);
    for (int i = 0; i < 3; i++) begin
      digin <= {rate_tab[i], cc_tab[i], 1'h1, 1'h0, i == 2, 7'h55};
      exp_q = '{HRF_LEN_DIGIN, {rate_tab[i], 6'h0}, rev8(cc_tab[i]),
        {5'h0, i != 2, 1'h0, i == 2}, 8'h55, HRF_RES_OK};
      run(HRF_OP_DIGIN_STAT, 6'h0, 0, 1'h0);
    end
    for (int f = 1; f < 4; f += 2) begin
      apb(HRF_CTRL_OFF, 1'h1, 32'(f));
      exp_q = '{8'h08, 16'hFF00, 16'hFF00, 0, 0, 0, 0, f == 1 ? 8'h3C : 8'h5A, 0, 8'h80};
      run(HRF_OP_STAT, 6'h0, 0, 1'h0);
    end
    apb(HRF_CTRL_OFF, 1'h1, 32'h2);
    for (int i = 0; i < 6; i++) begin
      e = 3'(i);
      t = 2'(i % 3 + 1);
      dec_stat <= {10'h0, e, 13'h1E1E, e, t, i[0], 4'h9, t - 2'h1, 2'h2, t, 6'h29};
      exp_q = '{HRF_LEN_MPEG, 16'hFF00, {8'hF8, 5'h0, e}, 0, 0, 8'hF0, {5'h1E, e},
        {4'h1, 1'h0, t, i[0]}, {4'h9, t - 2'h1, 2'h2}, {t, 6'h29}, 0, 0, 0, 8'h80};
      run(HRF_OP_STAT, 6'h0, 0, 1'h0);
    end
    apb(HRF_CTRL_OFF, 1'h1, 32'h0);
    exp_q = '{HRF_RES_OK};
    run(HRF_OP_STAT, 6'h0, 0, 1'h0);
    exp_q = '{HRF_RES_BAD_OP};
    run(HRF_OP_BAD, 6'h0, 0, 1'h0);
    exp_q = '{HRF_RES_NOT_READY, HRF_LEN_VER, 8'hA1, 8'hB2, 8'hC3, 8'hD4, HRF_RES_OK};
    run(HRF_OP_VERSION, 6'h0, 0, 1'h1);
    complete_run();
  end
endmodule
`default_nettype wire
